// File: hdl/dcst_pkg.sv
// Shared constants of the disk controller status and termination block
// Assumes an 8-bit host bus and an 8-bit auxiliary status bus
`default_nettype none
package dcst_pkg;
  // Register pointer values
  localparam logic [3:0] REG_CUR_HEAD  = 4'h4;
  localparam logic [3:0] REG_CUR_CYL   = 4'h5;
  localparam logic [3:0] REG_CHIP_ST   = 4'h8;
  localparam logic [3:0] REG_DRV_ST    = 4'h9;
  localparam logic [3:0] REG_TERM_MASK = 4'h9;
  localparam logic [3:0] REG_DATA      = 4'ha;
  // Command bytes
  localparam logic [7:0] CMD_RESET   = 8'h00;
  localparam logic [3:0] CMD_PTR_HI  = 4'h4;
  localparam logic [3:0] CMD_DSEL_HI = 4'h2;
  // Termination mask fields
  localparam int TM_INT_DONE = 5;
  localparam int TM_USER     = 3;
  localparam int TM_WP       = 2;
  localparam int TM_RDY      = 1;
  localparam int TM_WF       = 0;
  // Drive status fields
  localparam int DS_USER = 3;
  localparam int DS_WP   = 2;
  localparam int DS_RDY  = 1;
  localparam int DS_WF   = 0;
  // Chip event inputs, bit 5 down to 0 map to chip status 7 down to 2
  localparam int CE_SYNC = 1;
  localparam int CE_CMP  = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_PTR  = 4'h0;
  // Head load scale per drive type
  localparam logic [7:0] HL_SCALE_HARD = 8'h01;
  localparam logic [7:0] HL_SCALE_FL8  = 8'h02;
  localparam logic [7:0] HL_SCALE_FL5  = 8'h04;
  // Read data buffer
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;

  typedef enum logic [1:0] {
    TC_OK   = 2'b00,
    TC_RDID = 2'b01,
    TC_SEEK = 2'b10,
    TC_DATA = 2'b11
  } dcst_term_t;
endpackage
`default_nettype wire

// File: hdl/dcst_stream_if.sv
// Valid/ready byte stream between the block and its buffer
// Assumes one clock for both ends
`default_nettype none
interface dcst_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hdl/dcst_fifo.sv
// Synchronous FIFO with registered read data
// Assumes push and pop on the same clock; clr_i empties it
`default_nettype none
module dcst_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire logic     clr_i,
  dcst_stream_if.snk    in_if,
  dcst_stream_if.src    out_if
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [W-1:0]  dout_q;
  logic          ov_q;
  logic          push;
  logic          fetch;

  assign in_if.ready  = (cnt_q != FULL);
  assign push         = in_if.valid & in_if.ready;
  assign fetch        = (cnt_q != '0) & (~ov_q | out_if.ready);
  assign out_if.valid = ov_q;
  assign out_if.data  = dout_q;

  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_if.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (clr_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (fetch)
        rp_q <= rp_q + 1'b1;
      if (push & ~fetch)
        cnt_q <= cnt_q + 1'b1;
      else if (fetch & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // Output register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dout_q <= '0;
      ov_q   <= 1'b0;
    end
    else if (clr_i)
    begin
      ov_q <= 1'b0;
    end
    else if (fetch)
    begin
      dout_q <= mem_q[rp_q];
      ov_q   <= 1'b1;
    end
    else if (out_if.ready)
    begin
      ov_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: hdl/dcst_top.sv
// Status, interrupt and termination logic of a disk drive controller
// Assumes the command sequencer runs on clk_i; host and aux pins do not
// Function
// - Write protect ends write/format, sets done
// - Mask bit 1 lets ready change interrupt
// - Write fault ends write after current sector
// - Data register at 0AH, moved by DMA
// - Drive select scales data register head-load count
// - Current head loads from ID field
// - Current cylinder holds low cylinder bits
// - Interrupt status read drops interrupt, pending
// - Pending set by enabled done or ready change
// - DMA request set per byte, cleared by transfer
// - Done set on completion, cleared by command
// - Termination code preset per sequence, shown when done
// - Ready edge sets ready change, read clears
// - Late acknowledge sets overrun; reset only clears
// - Bad sector from head MSB, cleared otherwise
// - Chip status valid from done to command
// - Chip status flags; sync/compare errors terminate
// - Chip status low bits show selected drive
// - Drive status latched when aux bus free
// - Drive status bits follow aux bus lines
// - Status checked at command and sector boundaries
// - Mask bit 5 lets done interrupt
// - User-defined input ends command after sector
`default_nettype none
module dcst_top
  import dcst_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  host_data_bus_i,
  output logic [7:0]       host_data_bus_o,
  output logic             host_data_bus_oe_o,
  input  wire logic        host_strobe_n_i,
  input  wire logic        cmd_sel_i,
  input  wire logic        host_write_i,
  input  wire logic        dma_ack_i,
  output logic             dma_req_o,
  output logic             int_o,
  input  wire logic [7:0]  aux_bus_i,
  input  wire logic        aux_busy_i,
  input  wire logic [1:0]  drive_sel_i,
  input  wire logic [1:0]  drive_type_i,
  input  wire logic        write_op_i,
  input  wire logic        xfer_rd_i,
  input  wire logic        seq_enter_i,
  input  wire logic [1:0]  seq_code_i,
  input  wire logic        status_chk_i,
  input  wire logic        sector_end_i,
  input  wire logic        cmd_done_i,
  input  wire logic        id_valid_i,
  input  wire logic [7:0]  id_head_i,
  input  wire logic [7:0]  id_cyl_i,
  input  wire logic        byte_due_i,
  input  wire logic [5:0]  chip_ev_i,
  input  wire logic        disk_valid_i,
  input  wire logic [7:0]  disk_data_i,
  output logic             disk_ready_o,
  output logic             disk_wr_valid_o,
  output logic [7:0]       disk_wr_data_o,
  input  wire logic        disk_wr_take_i,
  output logic [7:0]       cmd_o,
  output logic             cmd_valid_o,
  output logic             term_o,
  output logic [15:0]      head_load_o
);
  function automatic logic [7:0] hl_scale(input logic [1:0] t);
    unique case (t)
      2'b00: hl_scale = HL_SCALE_HARD;
      2'b01: hl_scale = HL_SCALE_FL8;
      2'b10: hl_scale = HL_SCALE_FL5;
      2'b11: hl_scale = HL_SCALE_HARD;
    endcase
  endfunction

  // Pin synchronisers
  logic [11:0] pin_s1_q;
  logic [11:0] pin_s2_q;
  logic        stb_s3_q;
  logic [7:0]  aux_s1_q;
  logic [7:0]  aux_s2_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_s1_q <= 12'h800;
      pin_s2_q <= 12'h800;
      stb_s3_q <= 1'b1;
      aux_s1_q <= RST_BYTE;
      aux_s2_q <= RST_BYTE;
    end
    else
    begin
      pin_s1_q <= {host_strobe_n_i, cmd_sel_i, host_write_i, dma_ack_i, host_data_bus_i};
      pin_s2_q <= pin_s1_q;
      stb_s3_q <= pin_s2_q[11];
      aux_s1_q <= aux_bus_i;
      aux_s2_q <= aux_s1_q;
    end
  end

  logic       acc;
  logic       cd;
  logic       wr;
  logic       dack;
  logic [7:0] db;
  assign cd   = pin_s2_q[10];
  assign wr   = pin_s2_q[9];
  assign dack = pin_s2_q[8];
  assign db   = pin_s2_q[7:0];
  assign acc  = stb_s3_q & ~pin_s2_q[11];

  // Host access decode
  logic [3:0] ptr_q;
  logic       cmd_wr;
  logic       ist_rd;
  logic       soft_rst;
  logic       ptr_wr;
  logic       new_cmd;
  logic       reg_acc;
  logic       data_wr;
  logic       data_rd;
  logic       mask_wr;
  assign cmd_wr   = acc & cd & wr;
  assign ist_rd   = acc & cd & ~wr;
  assign soft_rst = cmd_wr & (db == CMD_RESET);
  assign ptr_wr   = cmd_wr & (db[7:4] == CMD_PTR_HI);
  assign new_cmd  = cmd_wr & ~soft_rst & ~ptr_wr;
  assign reg_acc  = acc & ~cd & ~dack;
  assign data_wr  = acc & ~cd & wr & (dack | (ptr_q == REG_DATA));
  assign data_rd  = acc & ~cd & ~wr & (dack | (ptr_q == REG_DATA));
  assign mask_wr  = reg_acc & wr & (ptr_q == REG_TERM_MASK);

  // Pointer, mask and command output
  logic [7:0] mask_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_q       <= RST_PTR;
      mask_q      <= RST_BYTE;
      cmd_o       <= RST_BYTE;
      cmd_valid_o <= 1'b0;
    end
    else if (soft_rst)
    begin
      ptr_q       <= RST_PTR;
      mask_q      <= RST_BYTE;
      cmd_o       <= CMD_RESET;
      cmd_valid_o <= 1'b0;
    end
    else
    begin
      cmd_valid_o <= new_cmd;
      if (ptr_wr)
        ptr_q <= db[3:0];
      if (mask_wr)
        mask_q <= db;
      if (new_cmd)
        cmd_o <= db;
    end
  end

  // Drive status latch
  logic [7:0] ds_q;
  logic       rdy_ev;
  assign rdy_ev = ~aux_busy_i & (aux_s2_q[DS_RDY] != ds_q[DS_RDY]);
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ds_q <= RST_BYTE;
    else if (~aux_busy_i)
      ds_q <= aux_s2_q;
  end

  // Termination decisions
  logic done_q;
  logic pend_q;
  logic wp_hit;
  logic pend_set;
  logic pend_end;
  logic err_stop;
  logic done_set;
  logic done_rise;
  assign wp_hit   = ~done_q & write_op_i & mask_q[TM_WP] & ds_q[DS_WP];
  assign pend_set = ~done_q & ((write_op_i & mask_q[TM_WF] & ds_q[DS_WF])
                    | (mask_q[TM_USER] & ds_q[DS_USER]));
  assign pend_end = (pend_q | pend_set) & (sector_end_i | status_chk_i);
  assign err_stop = chip_ev_i[CE_SYNC] | chip_ev_i[CE_CMP];
  assign done_set = cmd_done_i | wp_hit | pend_end | err_stop;
  assign done_rise = done_set & ~done_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pend_q <= 1'b0;
    else if (soft_rst | new_cmd | done_q)
      pend_q <= 1'b0;
    else if (pend_set)
      pend_q <= 1'b1;
  end

  // Done, termination code and termination strobe
  dcst_term_t term_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      done_q <= 1'b0;
      term_q <= TC_OK;
      term_o <= 1'b0;
    end
    else if (soft_rst)
    begin
      done_q <= 1'b0;
      term_q <= TC_OK;
      term_o <= 1'b0;
    end
    else
    begin
      term_o <= done_rise & ~cmd_done_i;
      if (done_set)
        done_q <= 1'b1;
      else if (new_cmd)
        done_q <= 1'b0;
      if (seq_enter_i)
        term_q <= dcst_term_t'(seq_code_i);
      else if (new_cmd)
        term_q <= TC_OK;
    end
  end

  // Interrupt pending and ready change
  logic int_pend_q;
  logic rdy_chg_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      int_pend_q <= 1'b0;
      rdy_chg_q  <= 1'b0;
    end
    else if (soft_rst)
    begin
      int_pend_q <= 1'b0;
      rdy_chg_q  <= 1'b0;
    end
    else
    begin
      if ((done_rise & mask_q[TM_INT_DONE]) | (rdy_ev & mask_q[TM_RDY]))
        int_pend_q <= 1'b1;
      else if (ist_rd)
        int_pend_q <= 1'b0;
      if (rdy_ev)
        rdy_chg_q <= 1'b1;
      else if (ist_rd)
        rdy_chg_q <= 1'b0;
    end
  end
  assign int_o = int_pend_q;

  // Read buffer between disk and data register
  dcst_stream_if #(.W(FIFO_W)) fill_if ();
  dcst_stream_if #(.W(FIFO_W)) drain_if ();
  logic full_q;
  assign fill_if.valid  = disk_valid_i;
  assign fill_if.data   = disk_data_i;
  assign disk_ready_o   = fill_if.ready;
  assign drain_if.ready = xfer_rd_i & ~dreq_q;

  dcst_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (soft_rst),
    .in_if  (fill_if),
    .out_if (drain_if)
  );

  // Data register, DMA request and overrun
  logic [7:0] data_q;
  logic       dreq_q;
  logic       ovr_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_q <= RST_BYTE;
      full_q <= 1'b0;
      dreq_q <= 1'b0;
      ovr_q  <= 1'b0;
    end
    else if (soft_rst)
    begin
      full_q <= 1'b0;
      dreq_q <= 1'b0;
      ovr_q  <= 1'b0;
    end
    else
    begin
      if (byte_due_i & dreq_q)
        ovr_q <= 1'b1;
      if (drain_if.valid & drain_if.ready)
      begin
        data_q <= drain_if.data;
        full_q <= 1'b1;
        dreq_q <= 1'b1;
      end
      else if (disk_wr_take_i & full_q & ~xfer_rd_i)
      begin
        full_q <= 1'b0;
        dreq_q <= 1'b1;
      end
      else if (data_wr)
      begin
        data_q <= db;
        full_q <= ~xfer_rd_i;
        dreq_q <= 1'b0;
      end
      else if (data_rd)
      begin
        full_q <= 1'b0;
        dreq_q <= 1'b0;
      end
    end
  end
  assign dma_req_o       = dreq_q;
  assign disk_wr_valid_o = full_q & ~xfer_rd_i;
  assign disk_wr_data_o  = data_q;

  // Head load count on drive select
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      head_load_o <= '0;
    else if (new_cmd & (db[7:4] == CMD_DSEL_HI))
      head_load_o <= data_q * hl_scale(drive_type_i);
  end

  // Current head, cylinder and bad sector
  logic [7:0] head_q;
  logic [7:0] cyl_q;
  logic       bad_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      head_q <= RST_BYTE;
      cyl_q  <= RST_BYTE;
      bad_q  <= 1'b0;
    end
    else if (soft_rst)
    begin
      bad_q <= 1'b0;
    end
    else
    begin
      if (id_valid_i)
      begin
        head_q <= id_head_i;
        cyl_q  <= id_cyl_i;
        bad_q  <= id_head_i[7];
      end
      else if (new_cmd)
        bad_q <= 1'b0;
    end
  end

  // Chip status flags
  logic [5:0] cs_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cs_q <= '0;
    else if (soft_rst)
      cs_q <= '0;
    else if (|chip_ev_i)
      cs_q <= (new_cmd ? 6'h00 : cs_q) | chip_ev_i;
    else if (new_cmd)
      cs_q <= '0;
  end

  // Read data path
  logic [7:0] ist;
  logic [7:0] rd_d;
  assign ist = {int_pend_q, dreq_q, done_q, term_q & {2{done_q}},
                rdy_chg_q, ovr_q, bad_q};

  always_comb
  begin
    rd_d = RST_BYTE;
    if (cd)
      rd_d = ist;
    else if (dack)
      rd_d = data_q;
    else
    begin
      unique case (ptr_q)
        REG_CUR_HEAD: rd_d = head_q;
        REG_CUR_CYL:  rd_d = cyl_q;
        REG_CHIP_ST:  rd_d = {cs_q, drive_sel_i};
        REG_DRV_ST:   rd_d = ds_q;
        REG_DATA:     rd_d = data_q;
        default:      rd_d = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      host_data_bus_o    <= RST_BYTE;
      host_data_bus_oe_o <= 1'b0;
    end
    else
    begin
      host_data_bus_oe_o <= ~pin_s2_q[11] & ~wr;
      if (acc & ~wr)
        host_data_bus_o <= rd_d;
    end
  end
endmodule
`default_nettype wire

// File: verification/dcst_sva.sv
// Port-level checks of the disk status and termination block
// Assumes it is bound to dcst_top, one clock domain
`default_nettype none
module dcst_sva (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       host_strobe_n_i,
  input wire logic       cmd_sel_i,
  input wire logic       host_write_i,
  input wire logic [7:0] host_data_bus_o,
  input wire logic       host_data_bus_oe_o,
  input wire logic       dma_req_o,
  input wire logic       int_o,
  input wire logic       cmd_valid_o,
  input wire logic       term_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  oe_strobe_a: assert property ($rose(host_data_bus_oe_o) |-> !$past(host_strobe_n_i))
    else $error("bus driven without strobe");
  oe_read_a: assert property ($rose(host_data_bus_oe_o) |-> !host_write_i)
    else $error("bus driven during a write");
  stat_bits_a: assert property ($rose(host_data_bus_oe_o) && cmd_sel_i && !host_write_i |->
    host_data_bus_o[7:6] == {$past(int_o), $past(dma_req_o)})
    else $error("status bits 7 and 6 wrong");
  int_clear_a: assert property ($rose(host_data_bus_oe_o) && cmd_sel_i && !host_write_i |->
    !int_o)
    else $error("interrupt kept after status read");
  term_code_a: assert property ($rose(host_data_bus_oe_o) && cmd_sel_i && !host_write_i &&
    !host_data_bus_o[5] |-> host_data_bus_o[4:3] == 2'b00)
    else $error("code shown while not done");
  cmd_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse too long");
  cmd_src_a: assert property (cmd_valid_o |-> cmd_sel_i && host_write_i && !host_strobe_n_i)
    else $error("command without command write");
  term_pulse_a: assert property (term_o |=> !term_o)
    else $error("termination pulse too long");
endmodule

bind dcst_top dcst_sva dcst_sva_inst (
  .clk_i, .rst_i, .host_strobe_n_i, .cmd_sel_i, .host_write_i, .host_data_bus_o,
  .host_data_bus_oe_o, .dma_req_o, .int_o, .cmd_valid_o, .term_o
);
`default_nettype wire

// File: verification/dcst_drive_model.sv
// Drive side model: status lines and a burst of read bytes
// Assumes the same clock and reset as the block
`default_nettype none
module dcst_drive_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] lines_i,
  input  wire logic [3:0] burst_i,
  input  wire logic       go_i,
  input  wire logic       ready_i,
  output logic [7:0]      aux_bus_o,
  output logic            valid_o,
  output logic [7:0]      data_o
);
  logic [3:0] left_q;
  assign aux_bus_o = lines_i;
  // Byte held until taken, then incremented; inverted once the last one is released
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      left_q  <= 4'h0;
      valid_o <= 1'b0;
      data_o  <= 8'h00;
    end
    else if (go_i && !valid_o)
    begin
      left_q  <= burst_i - 4'h1;
      valid_o <= 1'b1;
      data_o  <= 8'h10;
    end
    else if (valid_o && ready_i)
    begin
      left_q  <= left_q - 4'h1;
      valid_o <= (left_q != 4'h0);
      data_o  <= (left_q != 4'h0) ? data_o + 8'h01 : ~data_o;
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench of the disk status and termination block
// Assumes dcst_pkg, the block, its checker and the drive model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dcst_pkg::*;
  typedef struct packed {logic [7:0] aux; logic [7:0] exp;} dcst_row_t;
  dcst_row_t rows [8] = '{'{8'h01, 8'h01}, '{8'h02, 8'h02}, '{8'h04, 8'h04},
    '{8'h08, 8'h08}, '{8'h10, 8'h10}, '{8'h20, 8'h20}, '{8'h40, 8'h40}, '{8'h80, 8'h80}};
  logic [15:0] hl_exp [4] = '{16'h0003, 16'h0006, 16'h000c, 16'h0003};
  logic        clk_i = 1'b0, rst_i = 1'b1, go = 1'b0;
  logic [7:0]  host_data_bus_i = 8'h00, id_head_i = 8'h00, id_cyl_i = 8'h00, lines = 8'h00;
  logic        host_strobe_n_i = 1'b1, cmd_sel_i = 1'b0, host_write_i = 1'b0, dma_ack_i = 1'b0;
  logic [1:0]  drive_sel_i = 2'b00, drive_type_i = 2'b00, seq_code_i = 2'b00;
  logic        xfer_rd_i = 1'b0, seq_enter_i = 1'b0, cmd_done_i = 1'b0, id_valid_i = 1'b0;
  logic        byte_due_i = 1'b0, write_op_i = 1'b0;
  logic [5:0]  chip_ev_i = 6'h00;
  logic [7:0]  q;
  wire logic [7:0]  aux_bus_i, disk_data_i, host_data_bus_o;
  wire logic        disk_valid_i, disk_ready_o, dma_req_o, int_o;
  wire logic [15:0] head_load_o;
  int          bad_count = 0, cmp_count = 0;

  always #12.5 clk_i = ~clk_i;

  dcst_top dcst_top_inst (
    .clk_i, .rst_i, .host_data_bus_i, .host_data_bus_o, .host_data_bus_oe_o(),
    .host_strobe_n_i, .cmd_sel_i, .host_write_i, .dma_ack_i, .dma_req_o, .int_o,
    .aux_bus_i, .aux_busy_i(1'b0), .drive_sel_i, .drive_type_i, .write_op_i,
    .xfer_rd_i, .seq_enter_i, .seq_code_i, .status_chk_i(1'b0), .sector_end_i(1'b0),
    .cmd_done_i, .id_valid_i, .id_head_i, .id_cyl_i, .byte_due_i, .chip_ev_i,
    .disk_valid_i, .disk_data_i, .disk_ready_o, .disk_wr_valid_o(), .disk_wr_data_o(),
    .disk_wr_take_i(1'b0), .cmd_o(), .cmd_valid_o(), .term_o(), .head_load_o
  );
  dcst_drive_model dcst_drive_model_inst (
    .clk_i, .rst_i, .lines_i(lines), .burst_i(4'ha), .go_i(go), .ready_i(disk_ready_o),
    .aux_bus_o(aux_bus_i), .valid_o(disk_valid_i), .data_o(disk_data_i)
  );

  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // One strobed access; selects held around the strobe
  task automatic acc(input logic c, input logic w, input logic a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge clk_i);
    {cmd_sel_i, host_write_i, dma_ack_i, host_data_bus_i} <= {c, w, a, d};
    @(posedge clk_i);
    host_strobe_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    r = host_data_bus_o;
    host_strobe_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic rreg(input logic [3:0] p, output logic [7:0] r);
    acc(1'b1, 1'b1, 1'b0, {CMD_PTR_HI, p}, r);
    acc(1'b0, 1'b0, 1'b0, 8'h00, r);
  endtask

  task automatic wreg(input logic [3:0] p, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, 1'b1, 1'b0, {CMD_PTR_HI, p}, r);
    acc(1'b0, 1'b1, 1'b0, d, r);
  endtask

  // Pulses: enter, done, id, due, burst start, sync error
  task automatic pl(input logic [5:0] m);
    @(posedge clk_i);
    {seq_enter_i, cmd_done_i, id_valid_i, byte_due_i, go, chip_ev_i[1]} <= m;
    @(posedge clk_i);
    {seq_enter_i, cmd_done_i, id_valid_i, byte_due_i, go, chip_ev_i[1]} <= 6'h00;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic wint();
    int n;
    n = 0;
    while (int_o !== 1'b1 && n < 60)
    begin
      @(posedge clk_i);
      n++;
    end
    if (int_o !== 1'b1)
    begin
      bad_count++;
      print_verdict();
    end
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      lines <= rows[i].aux;
      rreg(REG_DRV_ST, q);
      chk(q, rows[i].exp);
    end
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h04);
    $display("drive status test done");
    wreg(REG_TERM_MASK, 8'h02);
    lines <= 8'h02;
    wint();
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h84);
    chk(int_o, 1'b0);
    wreg(REG_TERM_MASK, 8'h20);
    drive_sel_i <= 2'b11;
    acc(1'b1, 1'b1, 1'b0, 8'h5c, q);
    seq_code_i <= 2'b10;
    pl(6'h20);
    pl(6'h01);
    wint();
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'hb0);
    rreg(REG_CHIP_ST, q);
    chk(q, 8'h0b);
    seq_code_i <= 2'b00;
    acc(1'b1, 1'b1, 1'b0, 8'h5c, q);
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    pl(6'h20);
    pl(6'h10);
    wint();
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'ha0);
    $display("termination test done");
    id_head_i <= 8'h95;
    id_cyl_i <= 8'h33;
    pl(6'h08);
    rreg(REG_CUR_HEAD, q);
    chk(q, 8'h95);
    rreg(REG_CUR_CYL, q);
    chk(q, 8'h33);
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h21);
    wreg(REG_DATA, 8'h03);
    for (int t = 0; t < 4; t++)
    begin
      drive_type_i <= 2'(t);
      acc(1'b1, 1'b1, 1'b0, 8'h20, q);
      chk(head_load_o, hl_exp[t]);
    end
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    $display("register test done");
    wreg(REG_TERM_MASK, 8'h24);
    write_op_i <= 1'b1;
    lines <= 8'h06;
    wint();
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'ha0);
    write_op_i <= 1'b0;
    lines <= 8'h02;
    acc(1'b1, 1'b1, 1'b0, 8'h5c, q);
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    $display("protect test done");
    xfer_rd_i <= 1'b1;
    pl(6'h02);
    repeat (30) @(posedge clk_i);
    chk(disk_ready_o, 1'b0);
    chk(dma_req_o, 1'b1);
    pl(6'h04);
    for (int i = 0; i < 10; i++)
    begin
      acc(1'b0, 1'b0, 1'b1, 8'h00, q);
      chk(q, 8'h10 + 8'(i));
    end
    chk(dma_req_o, 1'b0);
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h02);
    acc(1'b1, 1'b1, 1'b0, 8'h5c, q);
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h02);
    acc(1'b1, 1'b1, 1'b0, CMD_RESET, q);
    acc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    $display("buffer test done");
    print_verdict();
  end
endmodule
`default_nettype wire
